// ===== design/erc_ext_read_reg.sv
// erc_ext_read_reg.sv: extended read control/status register behind an
// SPI-style command port (single-lane), plus error flag capture.
// assumes serial pins are async to mclk_i; op reports come from mclk_i logic.
// Operation
// - bits 7..5 select output drive strength
// - bit 0 mirrors status write-in-progress
// - bits 3..0 unchanged by set commands
// - bit 4 reserved, no function
// - opcode 85h nonvolatile, 83h volatile set
// - nonvolatile command writes nv copy, volatile volatile
// - protection flag on protected program/erase attempt
// - program flag on program or register failure
// - erase flag on erase or register failure
// - page program protected sets program and protection
// - info row program locked sets both flags
// - register update fail sets step's flag
// - locked status write sets protection and erase
// - erase fail or protected erase sets flags
// - chip erase protected hit sets nothing
// - one-time bits only go to one
// - read-only data bits ignored silently
// - error flags sticky until clear or reset
// - commands accepted while error flags set
`timescale 1ns/1ns
`default_nettype none
`include "erc_params.svh"

module erc_ext_read_reg
    import erc_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        nrst_i,
    input  wire logic        sck_i,
    input  wire logic        cs_n_i,
    input  wire logic        si_i,
    input  wire logic        sr_busy_i,
    input  wire erc_op_t     op_i,
    output logic             so_o,
    output logic             so_oe_o,
    output logic [2:0]       drive_strength_o,
    output logic [2:0]       nv_drive_strength_o,
    output logic             nv_write_req_o,
    output logic [7:0]       reg_value_o
);

    // synchronisers for the serial pins
    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    logic       sck_d_ff;

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            // idle levels: deselected, clock low, so no false edge after reset
            sync1_ff <= 3'h4;
            sync2_ff <= 3'h4;
            sck_d_ff <= 1'h0;
        end
        else
        begin
            sync1_ff <= {cs_n_i, sck_i, si_i};
            sync2_ff <= sync1_ff;
            sck_d_ff <= sync2_ff[1];
        end
    end

    logic cs_n_s;
    logic sck_s;
    logic si_s;
    logic sck_rise;
    logic sck_fall;

    // edge detection on the second stage only
    assign cs_n_s   = sync2_ff[2];
    assign sck_s    = sync2_ff[1];
    assign si_s     = sync2_ff[0];
    assign sck_rise = sck_s & ~sck_d_ff;
    assign sck_fall = ~sck_s & sck_d_ff;

    // frame and register state
    erc_state_t state_ff, nxt_state;
    logic [7:0] shift_ff, nxt_shift;
    logic [2:0] cnt_ff, nxt_cnt;
    logic [7:0] opc_ff, nxt_opc;
    logic [7:0] out_ff, nxt_out;
    logic       oe_ff, nxt_oe;
    logic       wel_ff, nxt_wel;
    logic [2:0] ds_v_ff, nxt_ds_v;
    logic [2:0] ds_nv_ff, nxt_ds_nv;
    logic       nvreq_ff, nxt_nvreq;
    logic       init_ff, nxt_init;
    logic       wip_ff, nxt_wip;
    erc_err_t   err_ff, nxt_err;
    erc_err_t   err_set;
    logic [7:0] reg_byte;
    logic [7:0] rx_byte;

    // live register image; bit 4 reserved reads its fixed value
    assign reg_byte = {ds_v_ff,
                       `ERC_RSVD_VALUE,
                       err_ff.erase_err, err_ff.prog_err, err_ff.prot_err,
                       wip_ff};

    assign rx_byte = {shift_ff[6:0], si_s};

    // error causes decoded from finished operations
    always_comb
    begin
        err_set = '0;
        if (op_i.done)
        begin
            if (op_i.is_prog)
            begin
                err_set.prog_err = op_i.fail_prog | op_i.prot_hit;
                err_set.prot_err = op_i.prot_hit;
            end
            if (op_i.is_erase)
            begin
                err_set.erase_err = op_i.fail_erase
                                  | (op_i.prot_hit & ~op_i.is_chip);
                err_set.prot_err  = op_i.prot_hit & ~op_i.is_chip;
            end
            if (op_i.is_nvreg)
            begin
                err_set.erase_err = err_set.erase_err | op_i.fail_erase;
                err_set.prog_err  = err_set.prog_err | op_i.fail_prog;
            end
            if (op_i.is_sr_wr & op_i.prot_hit)
            begin
                err_set.erase_err = 1'h1;
                err_set.prot_err  = 1'h1;
            end
        end
    end

    // command frame decoding and register next values
    always_comb
    begin
        nxt_state = state_ff;
        nxt_shift = shift_ff;
        nxt_cnt   = cnt_ff;
        nxt_opc   = opc_ff;
        nxt_out   = out_ff;
        nxt_oe    = oe_ff;
        nxt_wel   = wel_ff;
        nxt_ds_v  = ds_v_ff;
        nxt_ds_nv = ds_nv_ff;
        nxt_nvreq = 1'h0;
        nxt_init  = 1'h0;
        nxt_wip   = sr_busy_i;
        nxt_err   = err_ff;
        if (init_ff)
        begin
            nxt_ds_v = ds_nv_ff;
        end
        if (cs_n_s)
        begin
            nxt_state = ERC_IDLE;
            nxt_oe    = 1'h0;
            nxt_cnt   = 3'h0;
        end
        else
        begin
            case (state_ff)
                ERC_IDLE:
                begin
                    nxt_state = ERC_OPC;
                    nxt_cnt   = 3'h0;
                end
                ERC_OPC:
                begin
                    if (sck_rise)
                    begin
                        nxt_shift = rx_byte;
                        nxt_cnt   = cnt_ff + 3'h1;
                        if (cnt_ff == 3'h7)
                        begin
                            nxt_opc   = rx_byte;
                            nxt_state = ERC_DATA;
                            if (rx_byte == `ERC_OP_WRITE_ENABLE_CMD)
                            begin
                                nxt_wel = 1'h1;
                            end
                            else if (rx_byte == `ERC_OP_CLEAR)
                            begin
                                nxt_err = '0;
                            end
                            else if (rx_byte == `ERC_OP_READ)
                            begin
                                nxt_out = reg_byte;
                            end
                            else if (rx_byte != `ERC_OP_SET_NV && rx_byte != `ERC_OP_SET_V)
                            begin
                                nxt_state = ERC_SKIP;
                            end
                        end
                    end
                end
                ERC_DATA:
                begin
                    if (opc_ff == `ERC_OP_READ)
                    begin
                        if (sck_fall)
                        begin
                            nxt_oe = 1'h1;
                            if (oe_ff)
                            begin
                                nxt_out = {out_ff[6:0], out_ff[7]};
                            end
                        end
                    end
                    else if (sck_rise)
                    begin
                        nxt_shift = rx_byte;
                        nxt_cnt   = cnt_ff + 3'h1;
                        if (cnt_ff == 3'h7)
                        begin
                            nxt_state = ERC_SKIP;
                            if (wel_ff)
                            begin
                                nxt_wel = 1'h0;
                                // low five bits of the data byte are dropped
                                if (opc_ff == `ERC_OP_SET_NV)
                                begin
                                    nxt_ds_nv = rx_byte[`ERC_DS_MSB:`ERC_DS_LSB];
                                    nxt_nvreq = 1'h1;
                                end
                                else if (opc_ff == `ERC_OP_SET_V)
                                begin
                                    nxt_ds_v = rx_byte[`ERC_DS_MSB:`ERC_DS_LSB];
                                end
                            end
                        end
                    end
                end
                ERC_SKIP:
                begin
                    nxt_state = ERC_SKIP;
                end
                default:
                begin
                    nxt_state = ERC_IDLE;
                end
            endcase
        end
        // set wins over the clear in the same cycle
        nxt_err = nxt_err | err_set;
    end

    // register all state
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_ff <= ERC_IDLE;
            shift_ff <= 8'h00;
            cnt_ff   <= 3'h0;
            opc_ff   <= 8'h00;
            out_ff   <= 8'h00;
            oe_ff    <= 1'h0;
            wel_ff   <= 1'h0;
            ds_v_ff  <= `ERC_DS_RESET;
            ds_nv_ff <= `ERC_DS_RESET;
            nvreq_ff <= 1'h0;
            init_ff  <= 1'h1;
            wip_ff   <= 1'h0;
            err_ff   <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            shift_ff <= nxt_shift;
            cnt_ff   <= nxt_cnt;
            opc_ff   <= nxt_opc;
            out_ff   <= nxt_out;
            oe_ff    <= nxt_oe;
            wel_ff   <= nxt_wel;
            ds_v_ff  <= nxt_ds_v;
            ds_nv_ff <= nxt_ds_nv;
            nvreq_ff <= nxt_nvreq;
            init_ff  <= nxt_init;
            wip_ff   <= nxt_wip;
            err_ff   <= nxt_err;
        end
    end

    // outputs, all from flip-flops
    assign so_o                = out_ff[7];
    assign so_oe_o             = oe_ff;
    assign drive_strength_o    = ds_v_ff;
    assign nv_drive_strength_o = ds_nv_ff;
    assign nv_write_req_o      = nvreq_ff;
    assign reg_value_o         = reg_byte;

endmodule
`default_nettype wire

// ===== design/erc_params.svh
// erc_params.svh: offsets, field positions, reset values and opcodes of the
// extended read control/status register block.
// assumes inclusion by bare name from the design package and module.
`ifndef ERC_PARAMS_SVH
`define ERC_PARAMS_SVH

`define ERC_OP_SET_NV      8'h85
`define ERC_OP_SET_V       8'h83
`define ERC_OP_READ        8'h81
`define ERC_OP_CLEAR       8'h82
`define ERC_OP_WRITE_ENABLE_CMD        8'h06
`define ERC_BIT_WIP        0
`define ERC_BIT_PROT       1
`define ERC_BIT_PERR       2
`define ERC_BIT_EERR       3
`define ERC_BIT_RSVD       4
`define ERC_DS_LSB         5
`define ERC_DS_MSB         7
`define ERC_DS_RESET       3'h7
`define ERC_RSVD_VALUE     1'h1
`define ERC_DS_RSVD_A      3'h0
`define ERC_DS_RSVD_B      3'h4

`endif

// ===== design/erc_pkg.sv
// erc_pkg.sv: types shared by the extended read control/status block.
// assumes erc_params.svh is on the include path.
`include "erc_params.svh"
package erc_pkg;
    // state of the serial command frame
    typedef enum logic [3:0] {
        ERC_IDLE = 4'h1,
        ERC_OPC  = 4'h2,
        ERC_DATA = 4'h4,
        ERC_SKIP = 4'h8
    } erc_state_t;

    // one completed flash operation, reported by the array controller
    typedef struct packed {
        logic done;       // one-cycle pulse: operation finished
        logic is_prog;    // page, quad page or info row program
        logic is_erase;   // sector, block, chip or info row erase
        logic is_chip;    // chip erase (protected hits not flagged)
        logic is_nvreg;   // non-volatile register update
        logic is_sr_wr;   // status register write
        logic prot_hit;   // target protected, suspended or locked
        logic fail_prog;  // program step failed
        logic fail_erase; // erase step failed
    } erc_op_t;

    // error flags held in the register
    typedef struct packed {
        logic erase_err;
        logic prog_err;
        logic prot_err;
    } erc_err_t;
endpackage

// ===== sim/erc_ext_read_reg_asserts.sv
// erc_ext_read_reg_asserts.sv: port-level checker for the extended read register.
// assumes one clock domain, mclk_i, with async active-low reset nrst_i.
`timescale 1ns/1ns
`default_nettype none

module erc_ext_read_reg_asserts
    import erc_pkg::*;
(
    input wire logic       mclk_i,
    input wire logic       nrst_i,
    input wire logic       sck_i,
    input wire logic       cs_n_i,
    input wire logic       si_i,
    input wire logic       sr_busy_i,
    input wire erc_op_t    op_i,
    input wire logic       so_o,
    input wire logic       so_oe_o,
    input wire logic [2:0] drive_strength_o,
    input wire logic [2:0] nv_drive_strength_o,
    input wire logic       nv_write_req_o,
    input wire logic [7:0] reg_value_o
);
    logic [3:0] age_ff;
    logic [3:0] nxt_age;

    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (!nrst_i);

    // cycles since chip select was last low, saturating
    always_comb
    begin
        nxt_age = age_ff;
        if (!cs_n_i)
            nxt_age = 4'h0;
        else if (age_ff != 4'hF)
            nxt_age = age_ff + 4'h1;
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            age_ff <= 4'hF;
        else
            age_ff <= nxt_age;
    end

    // register image against its causes
    a_wip_mirror: assert property (1'h1 |=> reg_value_o[0] == $past(sr_busy_i))
        else $error("busy bit does not follow busy input");
    a_rsvd_one: assert property (reg_value_o[4] == 1'h1)
        else $error("reserved bit changed");
    a_ds_image: assert property ($changed(drive_strength_o) |-> age_ff < 4'hF)
        else $error("strength changed outside a command frame");
    a_prog_prot: assert property (op_i.done && op_i.is_prog && op_i.prot_hit |=> reg_value_o[2:1] == 2'h3)
        else $error("protected program flags missing");
    a_erase_prot: assert property (op_i.done && op_i.is_erase && !op_i.is_chip && op_i.prot_hit
        |=> reg_value_o[3] && reg_value_o[1])
        else $error("protected erase flags missing");
    a_status_lock: assert property (op_i.done && op_i.is_sr_wr && op_i.prot_hit |=> reg_value_o[3] && reg_value_o[1])
        else $error("locked status write flags missing");
    a_chip_quiet: assert property (op_i.done && op_i.is_chip && !op_i.is_prog && !op_i.is_sr_wr && !op_i.is_nvreg
        && !op_i.fail_erase && !reg_value_o[1] |=> !reg_value_o[1])
        else $error("chip erase raised protection flag");
    a_flag_sticky: assert property ($fell(reg_value_o[3]) || $fell(reg_value_o[2]) || $fell(reg_value_o[1])
        |-> age_ff < 4'hF)
        else $error("error flag dropped outside a frame");
    a_oe_idle: assert property (cs_n_i [*6] |-> !so_oe_o)
        else $error("output enabled while deselected");
    a_nvreq_pulse: assert property (nv_write_req_o |=> !nv_write_req_o)
        else $error("nonvolatile write request longer than a cycle");

    c_prot_op: cover property (op_i.done && op_i.prot_hit);
    c_nv_write: cover property (nv_write_req_o);
    c_read_out: cover property ($rose(so_oe_o));
endmodule

bind erc_ext_read_reg erc_ext_read_reg_asserts u_chk (.mclk_i(mclk_i), .nrst_i(nrst_i), .sck_i(sck_i),
    .cs_n_i(cs_n_i), .si_i(si_i), .sr_busy_i(sr_busy_i), .op_i(op_i), .so_o(so_o), .so_oe_o(so_oe_o),
    .drive_strength_o(drive_strength_o), .nv_drive_strength_o(nv_drive_strength_o),
    .nv_write_req_o(nv_write_req_o), .reg_value_o(reg_value_o));

`default_nettype wire

// ===== sim/erc_host.sv
// erc_host.sv: host model driving the serial command port in mode 0.
// assumes frame spaces frames itself with 200 ns deselected; sck stands low outside frames.
`timescale 1ns/1ns
`default_nettype none

module erc_host (
    output logic      sck_o,
    output logic      cs_n_o,
    output logic      si_o,
    input  wire logic so_i
);
    initial
    begin
        sck_o = 1'h0;
        cs_n_o = 1'h1;
        si_o = 1'h0;
    end

    // one byte msb first; data changes mid low phase, so sampled on each rise
    task automatic shift(input logic [7:0] b, input int hp, output logic [7:0] r);
        for (int i = 7; i >= 0; i--)
        begin
            #(hp / 2) si_o = b[i];
            #(hp / 2) sck_o = 1'h1;
            r = {r[6:0], so_i};
            #hp sck_o = 1'h0;
        end
    endtask

    // opcode, then n=1 a data byte or n=2 a slow read byte
    task automatic frame(input logic [7:0] op, input logic [7:0] d, input int n, output logic [7:0] r);
        logic [7:0] x;
        cs_n_o = 1'h0;
        #50 shift(op, 40, x);
        if (n == 1)
            shift(d, 40, x);
        if (n == 2)
            shift(8'h00, 80, r);
        #60 cs_n_o = 1'h1;
        si_o = ~si_o; // released line does not keep its last value
        #200;
    endtask
endmodule

`default_nettype wire

// ===== sim/erc_ext_read_reg_bench.sv
// erc_ext_read_reg_bench.sv: self-checking bench for the extended read register.
// assumes erc_host drives the serial pins and the checker is bound to dut.
`timescale 1ns/1ns
`default_nettype none
`include "erc_params.svh"

module erc_ext_read_reg_bench;
    import erc_pkg::*;
    typedef struct packed {
        logic [1:0] sel;
        logic [7:0] v;
    } erc_note_t;
    logic       mclk_i = 1'h0;
    logic       nrst_i = 1'h0;
    logic       srb = 1'h0;
    logic       sck, cs_n, si, so, so_oe, nvreq;
    logic [2:0] ds, nvds;
    logic [2:0] vds = 3'h7;
    logic [2:0] nv = 3'h7;
    logic [2:0] err = 3'h0;
    logic [7:0] regv, rd, d;
    logic [7:0] nreq = 8'h0;
    erc_op_t    opv = '0;
    erc_note_t  q[$];
    event       note_ev;
    int         fails = 0;
    int         n_checks = 0;
    int         seed = 32'hA149;
    logic [2:0] codes [6] = '{3'h1, 3'h7, 3'h3, 3'h6, 3'h2, 3'h5};
    logic [8:0] ops [8] = '{9'h182, 9'h184, 9'h141, 9'h144, 9'h164, 9'h111, 9'h112, 9'h10C};
    logic [2:0] errs [8] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h0, 3'h4, 3'h2, 3'h5};

    erc_ext_read_reg dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
        .sr_busy_i(srb), .op_i(opv), .so_o(so), .so_oe_o(so_oe), .drive_strength_o(ds),
        .nv_drive_strength_o(nvds), .nv_write_req_o(nvreq), .reg_value_o(regv));
    erc_host host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so));

    always #5 mclk_i = ~mclk_i;

    // count nonvolatile write requests
    always @(posedge mclk_i)
        if (nvreq === 1'h1)
            nreq <= nreq + 8'h1;

    function automatic logic [7:0] img();
        return {vds, 1'h1, err, srb};
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask

    // one cycle per note keeps every later input change at the same offset after the edge
    task automatic note(input logic [1:0] s, input logic [7:0] v);
        q.push_back('{s, v});
        -> note_ev;
        tick(1);
    endtask

    task automatic summarize();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // watcher takes the oldest note and compares it with the outputs
    always @(note_ev)
    begin : watch
        erc_note_t  e;
        logic [7:0] g;
        e = q.pop_front();
        g = e.sel == 2'h0 ? regv : e.sel == 2'h1 ? {2'h0, nvds, ds} : e.sel == 2'h2 ? rd : nreq;
        n_checks++;
        if (g !== e.v)
        begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, g, e.v);
        end
    end

    // stimulus: set commands, error reports, reads, clears, second reset
    initial
    begin
        repeat (16) @(posedge mclk_i);
        #1 nrst_i = 1'h1;
        tick(4);
        note(2'h0, img());
        host.frame(`ERC_OP_SET_V, 8'h20, 1, rd);
        note(2'h1, {2'h0, nv, vds});
        for (int i = 0; i < 6; i++)
        begin
            d = {codes[i], 5'($random(seed))};
            host.frame(`ERC_OP_WRITE_ENABLE_CMD, 8'h00, 0, rd);
            host.frame(i[0] ? `ERC_OP_SET_NV : `ERC_OP_SET_V, d, 1, rd);
            if (i[0])
                nv = codes[i];
            else
                vds = codes[i];
            note(2'h1, {2'h0, nv, vds});
            note(2'h0, img());
        end
        host.frame(`ERC_OP_SET_V, 8'h20, 1, rd);
        note(2'h1, {2'h0, nv, vds});
        note(2'h3, 8'h03);
        foreach (ops[i])
        begin
            @(posedge mclk_i);
            #1 opv = ops[i];
            srb = 1'($random(seed));
            err = errs[i];
            tick(1);
            opv = '0;
            note(2'h0, img());
            host.frame(`ERC_OP_READ, 8'h00, 2, rd);
            note(2'h2, img());
            host.frame(`ERC_OP_CLEAR, 8'h00, 0, rd);
            err = 3'h0;
            note(2'h0, img());
        end
        @(posedge mclk_i);
        #1 opv = 9'h182;
        srb = 1'h0;
        err = 3'h2;
        tick(1);
        opv = '0;
        note(2'h0, img());
        nrst_i = 1'h0;
        tick(2);
        nrst_i = 1'h1;
        tick(4);
        // reset returns both strength copies to the default and clears the flags
        nv = `ERC_DS_RESET;
        vds = nv;
        err = 3'h0;
        note(2'h0, img());
        note(2'h1, {2'h0, nv, vds});
        summarize();
    end

    // watchdog well beyond the expected run length
    initial
    begin
        #500000;
        fails++;
        summarize();
    end
endmodule

`default_nettype wire
